// file: tws_bus_peer.sv
// tws_bus_peer: behavioural far-side bus device, slave or master
`timescale 1ns/100ps
module tws_bus_peer
(
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    localparam int HALF_NS = 400;
    localparam int POLL_LIMIT = 20000;
    logic stuck = 1'b0;

    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // bounded poll; a line that never moves marks the peer stuck
    task automatic wait_lvl(input bit on_data, input logic lvl);
        int n;
        n = 0;
        while (((on_data ? sda : scl) !== lvl) && n < POLL_LIMIT)
        begin
            #50;
            n++;
        end
        if (n >= POLL_LIMIT)
            stuck = 1'b1;
    endtask : wait_lvl

    task automatic slave_take(input bit with_start, input logic ack, output logic [7:0] b);
        b = 8'h00;
        if (with_start)
        begin
            wait_lvl(1'b1, 1'b0);
            if (scl !== 1'b1)
                stuck = 1'b1;
        end
        for (int i = 7; i >= 0; i--)
        begin
            wait_lvl(1'b0, 1'b0);
            wait_lvl(1'b0, 1'b1);
            b[i] = sda;
        end
        wait_lvl(1'b0, 1'b0);
        sda_oe = ack;
        wait_lvl(1'b0, 1'b1);
        wait_lvl(1'b0, 1'b0);
        sda_oe = 1'b0;
    endtask : slave_take

    task automatic see_stop(output logic ok);
        wait_lvl(1'b0, 1'b1);
        ok = (sda === 1'b0);
        wait_lvl(1'b1, 1'b1);
        ok = ok && (scl === 1'b1);
    endtask : see_stop

    // 800 ns bit clock; data moves 100 ns after the clock falls
    task automatic master_send(input logic [7:0] b, output logic ack);
        sda_oe = 1'b1;
        #HALF_NS;
        for (int i = 7; i >= 0; i--)
        begin
            scl_oe = 1'b1;
            #100;
            sda_oe = !b[i];
            #300;
            scl_oe = 1'b0;
            wait_lvl(1'b0, 1'b1);
            #HALF_NS;
        end
        scl_oe = 1'b1;
        #100;
        sda_oe = 1'b0;
        #300;
        scl_oe = 1'b0;
        wait_lvl(1'b0, 1'b1);
        #200;
        ack = sda;
        #200;
        scl_oe = 1'b1;
    endtask : master_send

    task automatic master_stop();
        #100;
        sda_oe = 1'b1;
        #300;
        scl_oe = 1'b0;
        wait_lvl(1'b0, 1'b1);
        #HALF_NS;
        sda_oe = 1'b0;
    endtask : master_stop
endmodule : tws_bus_peer

// file: tws_ctrl.sv
// tws_ctrl: byte-level two-wire master/slave controller with register port
//
// Contract
// - enable bit routes pins to serial bus
// - enabled pins are driven open-drain only
// - master-select set: start, send data byte
// - master-select cleared by firmware: send stop
// - master drives lines, arbitrates, stretches clock
// - arbitration lost: drop master, flag, interrupt
// - addressed after loss: interrupt after transaction
// - proceed starts byte; reads busy
// - control writes ignored while busy
// - after interrupt stay idle until proceed
// - direction bit: one transmit, zero receive
// - first byte after start always transmitted
// - receive: ack bit drives acknowledge slot
// - transmit: ack bit reports receiver acknowledge
// - first-byte flag on address or loss
// - hardware clears restart bit during restart
// - stop-seen in slave receive unless nacked
// - data register holds eight-bit bus byte
// - interrupt per byte, stop, or loss; a stop sent as master raises none
// - hold clock low while awaiting firmware
// - separate transmit and receive byte stores
// - clock on pin bit zero, data bit one
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module tws_ctrl
#(
    parameter int HALF_BIT = tws_pkg::HALF_BIT_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire tws_pkg::tws_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic [1:0] pin_in,
    output tws_pkg::tws_pins_t pins,
    output logic serial_active,
    output logic irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;

    tws_sync u_sync_scl
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(pin_in[tws_pkg::PIN_CLOCK]),
        .sync_out(scl_s)
    );

    tws_sync u_sync_sda
    (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(pin_in[tws_pkg::PIN_DATA]),
        .sync_out(sda_s)
    );

    logic scl_prev_q;
    logic sda_prev_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    wire scl_rise = scl_s && !scl_prev_q;
    wire scl_fall = !scl_s && scl_prev_q;
    wire bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    wire bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_START = 9'h002,
        ST_LOW = 9'h004,
        ST_HIGH = 9'h008,
        ST_ACK_LOW = 9'h010,
        ST_ACK_HIGH = 9'h020,
        ST_WAIT = 9'h040,
        ST_STOP = 9'h080,
        ST_SLAVE = 9'h100
    } tws_state_t;

    tws_state_t state_q;
    logic [7:0] ctrl_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic [15:0] tmr_q;
    logic busy_q;
    logic first_tx_q;
    logic nacked_q;
    logic irq_held_q;
    logic sda_drive_low_q;
    logic scl_drive_low_q;
    logic bus_busy_q;

    wire wr_ctrl = bus_req.wr && bus_req.addr == tws_pkg::ADDR_STATUS_CONTROL && !busy_q;
    wire wr_byte = bus_req.wr && bus_req.addr == tws_pkg::ADDR_SERIAL_BYTE;
    wire rd_byte = bus_req.rd && bus_req.addr == tws_pkg::ADDR_SERIAL_BYTE;
    wire enabled = ctrl_q[tws_pkg::BIT_ENABLE];
    wire is_master = ctrl_q[tws_pkg::BIT_MASTER_SELECT];
    wire proceed_wr = wr_ctrl && bus_req.wdata[tws_pkg::BIT_PROCEED];
    wire tmr_done = tmr_q == 16'h0000;
    wire transmitting = first_tx_q || ctrl_q[tws_pkg::BIT_TRANSMIT];
    wire lost = is_master && state_q == ST_HIGH && transmitting && shift_q[7] && !sda_s;

    // ------------------------------------------------------------
    // transmit byte store and read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            tx_q <= 8'h00;
        else if (wr_byte)
            tx_q <= bus_req.wdata;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= 8'h00;
        else if (bus_req.rd)
        begin
            if (rd_byte)
                rdata <= rx_q;
            else if (bus_req.addr == tws_pkg::ADDR_STATUS_CONTROL)
                rdata <= {ctrl_q[7], busy_q, ctrl_q[5:0]};
            else
                rdata <= 8'h00;
        end
        else
            rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // bus occupancy as seen on the lines
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            bus_busy_q <= 1'b0;
        else if (bus_start)
            bus_busy_q <= 1'b1;
        else if (bus_stop)
            bus_busy_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // byte engine and control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            ctrl_q <= tws_pkg::STATUS_CONTROL_RESET;
            rx_q <= 8'h00;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            tmr_q <= 16'h0000;
            busy_q <= 1'b0;
            first_tx_q <= 1'b0;
            nacked_q <= 1'b0;
            irq_held_q <= 1'b0;
            irq <= 1'b0;
            sda_drive_low_q <= 1'b0;
            scl_drive_low_q <= 1'b0;
        end
        else
        begin
            irq <= 1'b0;
            if (!tmr_done)
                tmr_q <= tmr_q - 16'h0001;
            if (wr_ctrl)
            begin
                // busy and first-byte flag are hardware owned
                ctrl_q <= {bus_req.wdata[7], 1'b0, bus_req.wdata[5:4],
                           ctrl_q[tws_pkg::BIT_FIRST_BYTE], bus_req.wdata[2:0]};
                if (proceed_wr)
                begin
                    busy_q <= 1'b1;
                    ctrl_q[tws_pkg::BIT_FIRST_BYTE] <= 1'b0;
                    nacked_q <= !bus_req.wdata[tws_pkg::BIT_ACK] && !bus_req.wdata[5];
                end
                if (!bus_req.wdata[tws_pkg::BIT_ENABLE])
                begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                    sda_drive_low_q <= 1'b0;
                    scl_drive_low_q <= 1'b0;
                end
                else if (is_master && !bus_req.wdata[7])
                begin
                    state_q <= ST_STOP;
                    busy_q <= 1'b1;
                    sda_drive_low_q <= 1'b1;
                    scl_drive_low_q <= 1'b1;
                    tmr_q <= 16'(HALF_BIT);
                end
                else if (bus_req.wdata[7] && (!is_master || bus_req.wdata[2]))
                begin
                    // first byte after a start is always sent
                    state_q <= ST_START;
                    busy_q <= 1'b1;
                    first_tx_q <= 1'b1;
                    shift_q <= tx_q;
                    ctrl_q[tws_pkg::BIT_ARB_RESTART] <= 1'b0;
                    sda_drive_low_q <= 1'b0;
                    tmr_q <= 16'(HALF_BIT);
                end
            end

            case (state_q)
                ST_IDLE:
                begin
                    if (enabled && bus_start)
                    begin
                        state_q <= ST_SLAVE;
                        bit_q <= 4'h0;
                        first_tx_q <= 1'b0;
                        ctrl_q[tws_pkg::BIT_FIRST_BYTE] <= 1'b1;
                        ctrl_q[tws_pkg::BIT_TRANSMIT] <= 1'b0;
                        busy_q <= 1'b1;
                    end
                end
                ST_START:
                begin
                    // restart: release data, raise clock, then pull data low
                    if (tmr_done && !sda_drive_low_q)
                    begin
                        scl_drive_low_q <= 1'b0;
                        if (scl_s && !(bus_busy_q && !scl_drive_low_q && first_tx_q
                            && !ctrl_q[tws_pkg::BIT_ARB_RESTART] && 1'b0))
                        begin
                            sda_drive_low_q <= 1'b1;
                            tmr_q <= 16'(HALF_BIT);
                        end
                    end
                    else if (tmr_done)
                    begin
                        scl_drive_low_q <= 1'b1;
                        bit_q <= 4'h0;
                        state_q <= ST_LOW;
                        tmr_q <= 16'(HALF_BIT);
                    end
                end
                ST_LOW:
                begin
                    sda_drive_low_q <= transmitting ? !shift_q[7] : 1'b0;
                    if (tmr_done)
                    begin
                        scl_drive_low_q <= 1'b0;
                        state_q <= ST_HIGH;
                        tmr_q <= 16'(HALF_BIT);
                    end
                end
                ST_HIGH:
                begin
                    // clock stretching: count only once the line is really high
                    if (!scl_s)
                        tmr_q <= 16'(HALF_BIT);
                    else if (lost)
                    begin
                        ctrl_q[tws_pkg::BIT_MASTER_SELECT] <= 1'b0;
                        ctrl_q[tws_pkg::BIT_ARB_RESTART] <= 1'b1;
                        ctrl_q[tws_pkg::BIT_FIRST_BYTE] <= 1'b1;
                        sda_drive_low_q <= 1'b0;
                        scl_drive_low_q <= 1'b0;
                        irq_held_q <= 1'b1;
                        state_q <= ST_SLAVE;
                    end
                    else if (tmr_done)
                    begin
                        shift_q <= {shift_q[6:0], sda_s};
                        scl_drive_low_q <= 1'b1;
                        tmr_q <= 16'(HALF_BIT);
                        state_q <= (bit_q == 4'(tws_pkg::BYTE_BITS - 1)) ? ST_ACK_LOW : ST_LOW;
                        bit_q <= bit_q + 4'h1;
                    end
                end
                ST_ACK_LOW:
                begin
                    sda_drive_low_q <= !transmitting && ctrl_q[tws_pkg::BIT_ACK];
                    if (tmr_done)
                    begin
                        scl_drive_low_q <= 1'b0;
                        state_q <= ST_ACK_HIGH;
                        tmr_q <= 16'(HALF_BIT);
                    end
                end
                ST_ACK_HIGH:
                begin
                    if (!scl_s)
                        tmr_q <= 16'(HALF_BIT);
                    else if (tmr_done)
                    begin
                        if (transmitting)
                            ctrl_q[tws_pkg::BIT_ACK] <= !sda_s;
                        else
                            rx_q <= shift_q;
                        first_tx_q <= 1'b0;
                        scl_drive_low_q <= 1'b1;
                        sda_drive_low_q <= 1'b0;
                        busy_q <= 1'b0;
                        irq <= 1'b1;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // clock held low until firmware says go
                    if (proceed_wr && is_master && bus_req.wdata[7] && !bus_req.wdata[2])
                    begin
                        shift_q <= tx_q;
                        bit_q <= 4'h0;
                        state_q <= ST_LOW;
                        tmr_q <= 16'(HALF_BIT);
                    end
                end
                ST_STOP:
                begin
                    if (tmr_done && scl_drive_low_q)
                    begin
                        scl_drive_low_q <= 1'b0;
                        tmr_q <= 16'(HALF_BIT);
                    end
                    else if (tmr_done && scl_s)
                    begin
                        sda_drive_low_q <= 1'b0;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_SLAVE:
                begin
                    // byte handed up on every ninth falling edge; firmware acks it
                    if (bus_stop)
                    begin
                        if (!ctrl_q[tws_pkg::BIT_TRANSMIT] && !nacked_q
                            && !ctrl_q[tws_pkg::BIT_FIRST_BYTE])
                            ctrl_q[tws_pkg::BIT_STOP_SEEN] <= 1'b1;
                        irq <= !nacked_q || irq_held_q;
                        irq_held_q <= 1'b0;
                        sda_drive_low_q <= 1'b0;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else if (bus_start)
                    begin
                        bit_q <= 4'h0;
                        ctrl_q[tws_pkg::BIT_FIRST_BYTE] <= 1'b1;
                    end
                    else if (scl_rise)
                    begin
                        // rises counted, so the fall after a start is not a bit
                        bit_q <= bit_q + 4'h1;
                        if (bit_q < 4'(tws_pkg::BYTE_BITS))
                            shift_q <= {shift_q[6:0], sda_s};
                    end
                    else if (scl_fall && bit_q == 4'(tws_pkg::BYTE_BITS))
                    begin
                        // clock held low: firmware picks the acknowledge first
                        rx_q <= shift_q;
                        scl_drive_low_q <= 1'b1;
                        busy_q <= 1'b0;
                        irq <= !irq_held_q;
                    end
                    else if (scl_fall && bit_q == 4'(tws_pkg::BYTE_BITS + 1))
                    begin
                        bit_q <= 4'h0;
                        sda_drive_low_q <= 1'b0;
                    end
                    else if (proceed_wr && scl_drive_low_q)
                        sda_drive_low_q <= bus_req.wdata[tws_pkg::BIT_ACK]
                            && !bus_req.wdata[tws_pkg::BIT_TRANSMIT];
                    else if (scl_drive_low_q && busy_q)
                        scl_drive_low_q <= 1'b0;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // open-drain pins: only ever drive low
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins <= '0;
            serial_active <= 1'b0;
        end
        else
        begin
            serial_active <= enabled;
            pins.clock_o <= 1'b0;
            pins.data_o <= 1'b0;
            pins.clock_oe <= enabled && scl_drive_low_q;
            pins.data_oe <= enabled && sda_drive_low_q;
        end
    end
endmodule : tws_ctrl

// file: tws_ctrl_props.sv
// tws_ctrl_props: port-level assertions for the two-wire controller
`timescale 1ns/100ps
module tws_ctrl_props
#(
    parameter int HALF_BIT = tws_pkg::HALF_BIT_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire tws_pkg::tws_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic [1:0] pin_in,
    input wire tws_pkg::tws_pins_t pins,
    input wire logic serial_active,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // decoded requests
    // ------------------------------------------------------------
    logic sc_wr;
    logic go_wr;
    logic sc_rd;
    assign sc_wr = bus_req.wr && (bus_req.addr == tws_pkg::ADDR_STATUS_CONTROL);
    assign go_wr = sc_wr && bus_req.wdata[7] && bus_req.wdata[0];
    assign sc_rd = bus_req.rd && (bus_req.addr == tws_pkg::ADDR_STATUS_CONTROL);

    sequence s_go_then_read;
        go_wr ##1 sc_rd;
    endsequence
    // six quiet cycles: long enough to catch a bus that moves on alone
    sequence s_irq_no_firmware;
        irq ##1 (!sc_wr)[*6];
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_open_drain: assert property (!pins.clock_o && !pins.data_o)
        else $error("pin driven high");
    chk_off_released: assert property
        ((!serial_active && !$past(serial_active)) |-> !pins.clock_oe && !pins.data_oe)
        else $error("lines pulled while disabled");
    chk_enable_cause: assert property ($changed(serial_active) |-> $past(sc_wr, 2))
        else $error("enable moved without a write");
    chk_irq_pulse: assert property (irq |=> !irq)
        else $error("interrupt longer than one cycle");
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property
        ((bus_req.rd && bus_req.addr != tws_pkg::ADDR_STATUS_CONTROL
          && bus_req.addr != tws_pkg::ADDR_SERIAL_BYTE) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_go_busy: assert property (s_go_then_read |=> rdata[tws_pkg::BIT_PROCEED])
        else $error("master start not busy");
    chk_wait_firmware: assert property
        (s_irq_no_firmware |-> $stable(pins.clock_oe) && $stable(pins.data_oe))
        else $error("bus advanced without firmware");
endmodule : tws_ctrl_props

bind tws_ctrl tws_ctrl_props #(.HALF_BIT(HALF_BIT)) u_props
(
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata), .pin_in(pin_in),
    .pins(pins), .serial_active(serial_active), .irq(irq)
);

// file: tws_ctrl_tb.sv
// tws_ctrl_tb: register-level self-checking bench for the two-wire controller
`timescale 1ns/100ps
module tws_ctrl_tb;
    localparam logic [7:0] SC = tws_pkg::ADDR_STATUS_CONTROL;
    localparam logic [7:0] DB = tws_pkg::ADDR_SERIAL_BYTE;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    tws_pkg::tws_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    tws_pkg::tws_pins_t pins;
    logic serial_active;
    logic irq;
    logic scl;
    logic sda;
    logic peer_scl_oe;
    logic peer_sda_oe;
    logic [7:0] v;
    logic [7:0] got;
    logic flag;
    int n_fail = 0;
    int samples_checked = 0;

    // pulled-up open-drain wires
    assign scl = !(pins.clock_oe || peer_scl_oe);
    assign sda = !(pins.data_oe || peer_sda_oe);
    always #50 clk = ~clk;

    tws_ctrl #(.HALF_BIT(5)) dut
    (
        .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
        .pin_in({sda, scl}), .pins(pins), .serial_active(serial_active), .irq(irq)
    );
    tws_bus_peer peer (.scl(scl), .sda(sda), .scl_oe(peer_scl_oe), .sda_oe(peer_sda_oe));

    // ------------------------------------------------------------
    // register port and checking tasks
    // ------------------------------------------------------------
    // chained writes leave the strobe to the next call, no gap cycle
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input bit chain = 1'b0);
        bus_req <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        if (!chain)
        begin
            bus_req <= '0;
            @(posedge clk);
        end
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        bus_req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 d = rdata;
        @(posedge clk);
    endtask : bus_rd

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk8

    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic wait_irq();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (irq !== 1'b1 && n < 3000);
        if (n >= 3000)
        begin
            n_fail++;
            wrap_up();
        end
        @(posedge clk);
    endtask : wait_irq

    task automatic peer_check();
        if (peer.stuck)
        begin
            n_fail++;
            wrap_up();
        end
    endtask : peer_check

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus_rd(SC, v);
        chk8("control reset", tws_pkg::STATUS_CONTROL_RESET, v);
        bus_rd(8'h2A, v);
        chk8("unmapped", 8'h00, v);
        bus_wr(SC, 8'h01);
        #1 chk8("enable", 8'h01, {7'h00, serial_active});
        chk8("idle lines", 8'h03, {6'h00, sda, scl});
        bus_wr(DB, 8'hA6);
        fork
            peer.slave_take(1'b1, 1'b1, got);
            begin
                // direction left at receive: first byte goes out anyway
                bus_wr(SC, 8'h81, 1'b1);
                bus_rd(SC, v);
                chk8("busy", 8'h40, v & 8'h40);
                bus_wr(SC, 8'h01);
                wait_irq();
            end
        join
        peer_check();
        chk8("address byte", 8'hA6, got);
        chk8("clock held", 8'h00, {7'h00, scl});
        bus_rd(SC, v);
        chk8("after ack", 8'h91, v);
        bus_wr(DB, 8'h3C);
        fork
            peer.slave_take(1'b0, 1'b0, got);
            begin
                bus_wr(SC, 8'hE1);
                wait_irq();
            end
        join
        peer_check();
        chk8("data byte", 8'h3C, got);
        bus_rd(SC, v);
        chk8("after nack", 8'hA1, v);
        bus_wr(DB, 8'hA7);
        fork
            peer.slave_take(1'b1, 1'b1, got);
            begin
                bus_wr(SC, 8'hC5);
                wait_irq();
            end
        join
        peer_check();
        chk8("restart byte", 8'hA7, got);
        bus_rd(SC, v);
        chk8("restart cleared", 8'h91, v);
        fork
            peer.see_stop(flag);
            bus_wr(SC, 8'h01);
        join
        peer_check();
        chk8("stop", 8'h01, {7'h00, flag});
        // far-side edges away from the sampling edge of clk
        @(negedge clk);
        fork
            peer.master_send(8'h5A, flag);
            begin
                wait_irq();
                bus_rd(SC, v);
                chk8("first byte", 8'h09, v);
                bus_rd(DB, v);
                chk8("rx byte", 8'h5A, v);
                bus_wr(SC, 8'h51);
            end
        join
        peer_check();
        chk8("ack driven", 8'h00, {7'h00, flag});
        fork
            peer.master_stop();
            wait_irq();
        join
        bus_rd(SC, v);
        chk8("stop seen", 8'h02, v & 8'h4A);
        bus_wr(SC, 8'h00);
        #1 chk8("disable", 8'h00, {7'h00, serial_active});
        wrap_up();
    end
endmodule : tws_ctrl_tb

// file: tws_pkg.sv
// tws_pkg: constants and types shared by the two-wire serial controller
package tws_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h28;
    localparam logic [7:0] ADDR_SERIAL_BYTE = 8'h29;
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------
    // status/control bit positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE = 0;
    localparam int BIT_STOP_SEEN = 1;
    localparam int BIT_ARB_RESTART = 2;
    localparam int BIT_FIRST_BYTE = 3;
    localparam int BIT_ACK = 4;
    localparam int BIT_TRANSMIT = 5;
    localparam int BIT_PROCEED = 6;
    localparam int BIT_MASTER_SELECT = 7;

    // ------------------------------------------------------------
    // pin positions and timing
    // ------------------------------------------------------------
    localparam int PIN_CLOCK = 0;
    localparam int PIN_DATA = 1;
    localparam int CLK_HZ = 10_000_000;
    localparam int BUS_HZ = 100_000;
    // half bit period, rounded down so the bus never runs slower than documented
    localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * BUS_HZ);
    localparam int BYTE_BITS = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tws_bus_req_t;

    typedef struct packed {
        logic clock_o;
        logic clock_oe;
        logic data_o;
        logic data_oe;
    } tws_pins_t;

endpackage : tws_pkg

// file: tws_sync.sv
// tws_sync: two-flip-flop synchroniser for one pin input
`timescale 1ns/100ps
module tws_sync
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : tws_sync
